// File: include/soc_defs.vh
`ifndef SOC_DEFS_VH
`define SOC_DEFS_VH

// Register byte addresses
`define SOC_REG_ONE_ADDR 4'h0
`define SOC_REG_TWO_ADDR 4'h4
`define SOC_REG_STAT_ADDR 4'h8
`define SOC_REG_EVT_ADDR 4'hC

// Register one fields
`define SOC_R1_BAUD_SEL 0
`define SOC_R1_XTAL_EN 1
`define SOC_R1_EXTCLK_EN 2
`define SOC_R1_KEEP_OSC 3

// Register two fields
`define SOC_R2_LVM_RST_DIS 0
`define SOC_R2_LVM_PWR_DIS 1
`define SOC_R2_LVM_TRIP 2
`define SOC_R2_SHORT_REC 3
`define SOC_R2_STOP_EN 4
`define SOC_R2_WDOG_DIS 5

// Event register fields (write one to request)
`define SOC_EV_STOP 0
`define SOC_EV_WAKE 1
`define SOC_EV_LVM_WAKE 2

// Reset values
`define SOC_R1_RESET 8'h00
`define SOC_R2_RESET 8'h00

// Timing counts in oscillator output clock cycles
`define SOC_LONG_REC 4096
`define SOC_SHORT_REC 32
`define SOC_XTAL_STAB 4096
`define SOC_EXT_STAB 16

// AXI responses
`define SOC_RESP_OKAY 2'b00
`define SOC_RESP_SLVERR 2'b10

`endif

// File: verilog/soc_system_option.v
`timescale 1ns/1ps
`include "soc_defs.vh"

// Behaviour
// - Serial port clock from bus clock when select bit is 1, else oscillator clock.
// - Crystal enable affects pin two only when external clock enable is set; monitor range and divider follow it regardless.
// - External clock enable 0: oscillator off, both pins stay port pins.
// - External clock only: pin one takes square wave, pin two stays port pin.
// - Both enables: both pins form crystal; square wave on pin one still works.
// - Crystal enable selects crystal monitor range, else wide external range.
// - Stabilization divider 4096 cycles with crystal, 16 cycles without.
// - Crystal enable resets clear, leaving pin two a port pin.
// - Reset disable bit 1 blocks low-voltage monitor resets.
// - Power disable bit 1 removes low-voltage monitor power.
// - Trip mode 1 selects 5 V trip points, 0 selects 3 V.
// - Trip mode bit cleared only by power-on reset.
// - Stop exit after 32 cycles with short recovery, else 4096.
// - Stop exit by low-voltage monitor reset always uses long recovery.
// - Oscillator off in stop for internal or crystal source unless kept.
// - After power-on reset and long recovery, wait 4096 cycles before running.
// - Stop instruction executes when enabled, else illegal opcode.
// - Watchdog disable bit 1 disables the watchdog.
module soc_system_option (
   input wire clk_in,
   input wire rst_in,
   input wire por_in,
   input wire osc_tick_in,
   input wire stop_exec_in,
   input wire lvm_reset_req_in,
   input wire [3:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [3:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   output reg serial_baud_clock_select_out,
   output reg ext_osc_enable_out,
   output reg oscillator_pin_one_clock_out,
   output reg oscillator_pin_two_crystal_out,
   output reg monitor_crystal_range_out,
   output reg stab_long_out,
   output reg lvm_reset_enable_out,
   output reg low_voltage_monitor_power_out,
   output reg voltage_monitor_trip_mode_out,
   output reg stop_enable_out,
   output reg stop_illegal_out,
   output reg watchdog_enable_out,
   output reg osc_off_in_stop_out,
   output reg in_stop_out,
   output reg cpu_run_out,
   output reg lvm_reset_out
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [2:0] sync_a;
   reg [2:0] sync_b;
   wire [2:0] sync_src;
   wire osc_tick;
   reg osc_tick_prev;
   wire osc_edge;
   genvar gi;

   // No reset here: power-on must get through while rst_in is held,
   // and a cleared edge history would fake an oscillator edge at release
   assign sync_src = {lvm_reset_req_in, por_in, osc_tick_in};

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clk_in) begin
            sync_a[gi] <= sync_src[gi];
            sync_b[gi] <= sync_a[gi];
         end
      end
   endgenerate

   always @(posedge clk_in) begin
      osc_tick_prev <= sync_b[0];
   end

   // Oscillator output clock is counted as rising edges of its sampled level
   assign osc_tick = sync_b[0];
   assign osc_edge = osc_tick & ~osc_tick_prev;

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   reg [7:0] reg_one;
   reg [7:0] reg_two;
   reg trip_mode;

   wire wr_fire;
   wire rd_fire;
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_lane0;

   assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
   assign wr_data = w_held ? w_data : s_axi_wdata_in;
   assign wr_strb = w_held ? w_strb : s_axi_wstrb_in;
   // Commit once, when both channels are held, so an event write pulses only once
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid_out;
   assign wr_lane0 = wr_fire & wr_strb[0];

   // General resets leave everything but the trip mode to reset values
   always @(posedge clk_in) begin
      if (rst_in) begin
         reg_one <= `SOC_R1_RESET;
         reg_two <= `SOC_R2_RESET;
      end else if (wr_lane0 && wr_addr == `SOC_REG_ONE_ADDR) begin
         reg_one <= {4'h0, wr_data[3:0]};
      end else if (wr_lane0 && wr_addr == `SOC_REG_TWO_ADDR) begin
         reg_two <= {2'h0, wr_data[5:3], 1'b0, wr_data[1:0]};
      end
   end

   // Trip mode: power-on reset only, other resets leave it
   always @(posedge clk_in) begin
      if (sync_b[1]) begin
         trip_mode <= 1'b0;
      end else if (!rst_in && wr_lane0 && wr_addr == `SOC_REG_TWO_ADDR) begin
         trip_mode <= wr_data[`SOC_R2_LVM_TRIP];
      end
   end

   // ----------------------------------------
   // Stop and recovery sequencer
   // ----------------------------------------
   localparam ST_RUN = 4'b0001;
   localparam ST_STOP = 4'b0010;
   localparam ST_RECOVER = 4'b0100;
   localparam ST_PORWAIT = 4'b1000;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [12:0] rec_count;
   reg [12:0] rec_target;
   reg [12:0] next_target;
   reg lvm_wake;
   reg wake_req;

   wire ext_en;
   wire xtal_active;
   wire lvm_reset_fire;

   assign ext_en = reg_one[`SOC_R1_EXTCLK_EN];
   assign xtal_active = ext_en & reg_one[`SOC_R1_XTAL_EN];
   assign lvm_reset_fire = sync_b[2] & ~reg_two[`SOC_R2_LVM_RST_DIS];

   always @* begin
      next_state = state;
      next_target = rec_target;
      case (state)
         ST_RUN: begin
            if (stop_exec_in && reg_two[`SOC_R2_STOP_EN]) begin
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (lvm_reset_fire) begin
               next_state = ST_RECOVER;
               next_target = 13'd`SOC_LONG_REC;
            end else if (wake_req) begin
               next_state = ST_RECOVER;
               next_target = reg_two[`SOC_R2_SHORT_REC] ? 13'd`SOC_SHORT_REC : 13'd`SOC_LONG_REC;
            end
         end
         ST_RECOVER: begin
            if (osc_edge && rec_count == rec_target - 13'd1) begin
               next_state = ST_RUN;
            end
         end
         ST_PORWAIT: begin
            if (osc_edge && rec_count == 13'd`SOC_LONG_REC - 13'd1) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_PORWAIT;
         end
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_PORWAIT;
         rec_count <= 13'h0;
         rec_target <= 13'd`SOC_LONG_REC;
         lvm_wake <= 1'b0;
      end else begin
         state <= next_state;
         rec_target <= next_target;
         if (next_state != state) begin
            rec_count <= 13'h0;
         end else if (osc_edge) begin
            rec_count <= rec_count + 13'd1;
         end
         if (state == ST_STOP && next_state == ST_RECOVER) begin
            lvm_wake <= lvm_reset_fire;
         end
      end
   end

   // Wake requests arrive as writes to the event register
   always @(posedge clk_in) begin
      if (rst_in) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= wr_lane0 && wr_addr == `SOC_REG_EVT_ADDR && wr_data[`SOC_EV_WAKE];
      end
   end

   // ----------------------------------------
   // Control outputs, all registered
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (rst_in) begin
         serial_baud_clock_select_out <= 1'b0;
         ext_osc_enable_out <= 1'b0;
         oscillator_pin_one_clock_out <= 1'b0;
         oscillator_pin_two_crystal_out <= 1'b0;
         monitor_crystal_range_out <= 1'b0;
         stab_long_out <= 1'b0;
         lvm_reset_enable_out <= 1'b1;
         low_voltage_monitor_power_out <= 1'b1;
         voltage_monitor_trip_mode_out <= 1'b0;
         stop_enable_out <= 1'b0;
         stop_illegal_out <= 1'b0;
         watchdog_enable_out <= 1'b1;
         osc_off_in_stop_out <= 1'b0;
         in_stop_out <= 1'b0;
         cpu_run_out <= 1'b0;
         lvm_reset_out <= 1'b0;
      end else begin
         serial_baud_clock_select_out <= reg_one[`SOC_R1_BAUD_SEL];
         ext_osc_enable_out <= ext_en;
         oscillator_pin_one_clock_out <= ext_en;
         oscillator_pin_two_crystal_out <= xtal_active;
         monitor_crystal_range_out <= reg_one[`SOC_R1_XTAL_EN];
         stab_long_out <= reg_one[`SOC_R1_XTAL_EN];
         lvm_reset_enable_out <= ~reg_two[`SOC_R2_LVM_RST_DIS];
         low_voltage_monitor_power_out <= ~reg_two[`SOC_R2_LVM_PWR_DIS];
         voltage_monitor_trip_mode_out <= trip_mode;
         stop_enable_out <= reg_two[`SOC_R2_STOP_EN];
         stop_illegal_out <= stop_exec_in & ~reg_two[`SOC_R2_STOP_EN];
         watchdog_enable_out <= ~reg_two[`SOC_R2_WDOG_DIS];
         // Internal oscillator or crystal source, not kept alive
         osc_off_in_stop_out <= (state == ST_STOP) & (~ext_en | xtal_active)
            & ~reg_one[`SOC_R1_KEEP_OSC];
         in_stop_out <= (state == ST_STOP);
         cpu_run_out <= (state == ST_RUN);
         lvm_reset_out <= lvm_reset_fire;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   wire addr_ok_w;
   wire addr_ok_r;
   reg [31:0] rd_word;

   assign addr_ok_w = (wr_addr == `SOC_REG_ONE_ADDR) | (wr_addr == `SOC_REG_TWO_ADDR)
      | (wr_addr == `SOC_REG_EVT_ADDR);
   assign addr_ok_r = (s_axi_araddr_in == `SOC_REG_ONE_ADDR) | (s_axi_araddr_in == `SOC_REG_TWO_ADDR)
      | (s_axi_araddr_in == `SOC_REG_STAT_ADDR) | (s_axi_araddr_in == `SOC_REG_EVT_ADDR);
   assign rd_fire = s_axi_arvalid_in & s_axi_arready_out;

   always @* begin
      case (s_axi_araddr_in)
         `SOC_REG_ONE_ADDR: rd_word = {24'h00_0000, reg_one};
         `SOC_REG_TWO_ADDR: rd_word = {24'h00_0000, reg_two[7:3], trip_mode, reg_two[1:0]};
         `SOC_REG_STAT_ADDR: rd_word = {27'h000_0000, lvm_wake, state};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `SOC_RESP_OKAY;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `SOC_RESP_OKAY;
      end else begin
         s_axi_awready_out <= ~aw_held & ~s_axi_awready_out & s_axi_awvalid_in & ~s_axi_bvalid_out;
         s_axi_wready_out <= ~w_held & ~s_axi_wready_out & s_axi_wvalid_in & ~s_axi_bvalid_out;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (aw_held && w_held && !s_axi_bvalid_out) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= addr_ok_w ? `SOC_RESP_OKAY : `SOC_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
         if (rd_fire) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= addr_ok_r ? `SOC_RESP_OKAY : `SOC_RESP_SLVERR;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

endmodule // soc_system_option

// File: verification/soc_system_option_props.sv
`timescale 1ns/1ps
module soc_props (
   input wire clk_in,
   input wire rst_in,
   input wire stop_exec_in,
   input wire s_axi_wready_out,
   input wire s_axi_bready_in,
   input wire s_axi_bvalid_out,
   input wire [1:0] s_axi_bresp_out,
   input wire ext_osc_enable_out,
   input wire oscillator_pin_one_clock_out,
   input wire oscillator_pin_two_crystal_out,
   input wire monitor_crystal_range_out,
   input wire stab_long_out,
   input wire lvm_reset_enable_out,
   input wire lvm_reset_out,
   input wire stop_enable_out,
   input wire stop_illegal_out,
   input wire in_stop_out,
   input wire cpu_run_out,
   input wire osc_off_in_stop_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   AST_PIN_ONE: assert property (oscillator_pin_one_clock_out == ext_osc_enable_out)
      else $error("pin one use differs from ext enable");
   AST_PIN_TWO: assert property (oscillator_pin_two_crystal_out |-> ext_osc_enable_out)
      else $error("crystal pin without ext enable");
   AST_STAB: assert property (stab_long_out == monitor_crystal_range_out)
      else $error("divider and range disagree");
   AST_LVM: assert property (lvm_reset_out |-> lvm_reset_enable_out)
      else $error("monitor reset while disabled");
   AST_ILLEGAL: assert property (stop_exec_in && !stop_enable_out && cpu_run_out |=> stop_illegal_out)
      else $error("disabled stop not flagged");
   AST_STOP: assert property (stop_exec_in && stop_enable_out && cpu_run_out |-> ##[1:3] in_stop_out)
      else $error("stop not entered");
   AST_EXCL: assert property (!(in_stop_out && cpu_run_out))
      else $error("running while stopped");
   AST_OSC: assert property (osc_off_in_stop_out |-> in_stop_out || $past(in_stop_out))
      else $error("oscillator off outside stop");
   AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   AST_STEADY: assert property ($changed(stop_enable_out) |-> $past(s_axi_wready_out) || $past(s_axi_wready_out, 2) || $past(s_axi_wready_out, 3))
      else $error("setting moved without write");
   cover property (stop_illegal_out);
   cover property ($fell(in_stop_out));
   cover property (osc_off_in_stop_out);
endmodule // soc_props

bind soc_system_option soc_props u_props (.*);

// File: verification/soc_far_side.sv
`timescale 1ns/1ps
module soc_far_side (
   input wire clk_in,
   input wire cpu_run_in,
   input wire stop_cmd_in,
   output reg osc_tick_out,
   output reg stop_exec_out
);
   reg [1:0] div = 2'b00;
   initial begin
      osc_tick_out = 1'b0;
      stop_exec_out = 1'b0;
   end
   // Free running oscillator, one rising edge per four system clocks
   always @(posedge clk_in) begin
      div <= div + 2'b01;
      osc_tick_out <= div[1];
      stop_exec_out <= stop_cmd_in && cpu_run_in;
   end
endmodule // soc_far_side

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg por_in = 1'b1;
   reg lvm_reset_req_in = 1'b0;
   reg stop_cmd = 1'b0;
   reg [3:0] s_axi_awaddr_in = 4'h0;
   reg [3:0] s_axi_araddr_in = 4'h0;
   reg [3:0] s_axi_wstrb_in = 4'hf;
   reg [31:0] s_axi_wdata_in = 32'h0000_0000;
   reg s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   reg s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   wire osc_tick_in, stop_exec_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   wire s_axi_arready_out, s_axi_rvalid_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   wire serial_baud_clock_select_out, ext_osc_enable_out, oscillator_pin_one_clock_out;
   wire oscillator_pin_two_crystal_out, monitor_crystal_range_out, stab_long_out, lvm_reset_enable_out;
   wire low_voltage_monitor_power_out, voltage_monitor_trip_mode_out, stop_enable_out, stop_illegal_out;
   wire watchdog_enable_out, osc_off_in_stop_out, in_stop_out, cpu_run_out, lvm_reset_out;
   wire [10:0] cfg = {serial_baud_clock_select_out, ext_osc_enable_out, oscillator_pin_one_clock_out,
      oscillator_pin_two_crystal_out, monitor_crystal_range_out, stab_long_out, lvm_reset_enable_out,
      low_voltage_monitor_power_out, voltage_monitor_trip_mode_out, stop_enable_out, watchdog_enable_out};
   bit [7:0] m1, m2;
   bit trip, k;
   integer err_total = 0, checks = 0, cyc = 0, seed = 67641, n, i;
   reg [31:0] rd_d;
   reg [1:0] rsp;

   soc_system_option u_dut (.*);
   soc_far_side u_far (.clk_in(clk_in), .cpu_run_in(cpu_run_out), .stop_cmd_in(stop_cmd),
      .osc_tick_out(osc_tick_in), .stop_exec_out(stop_exec_in));

   initial begin
      forever #5 clk_in = ~clk_in;
   end

   function automatic [10:0] ex();
      ex = {m1[0], m1[2], m1[2], m1[2] & m1[1], m1[1], m1[1], ~m2[0], ~m2[1], trip, m2[4], ~m2[5]};
   endfunction

   task automatic cmp(input [31:0] got, input [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input [3:0] a, input [31:0] d);
      bit aw, w, done;
      aw = 1;
      w = 1;
      done = 0;
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      while (!done) begin
         @(posedge clk_in);
         if (aw && s_axi_awready_out) begin
            aw = 0;
            s_axi_awvalid_in <= 1'b0;
         end
         if (w && s_axi_wready_out) begin
            w = 0;
            s_axi_wvalid_in <= 1'b0;
         end
         if (s_axi_bvalid_out) begin
            done = 1;
            rsp = s_axi_bresp_out;
            s_axi_bready_in <= 1'b0;
         end
      end
      if (a == 4'h0) m1 = d[7:0] & 8'h0f;
      if (a == 4'h4) m2 = d[7:0] & 8'h3f;
      if (a == 4'h4) trip = d[2];
      cmp(rsp, 2'b00);
   endtask

   task automatic rd(input [3:0] a);
      bit ar, done;
      ar = 1;
      done = 0;
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      while (!done) begin
         @(posedge clk_in);
         if (ar && s_axi_arready_out) begin
            ar = 0;
            s_axi_arvalid_in <= 1'b0;
         end
         if (s_axi_rvalid_out) begin
            done = 1;
            rd_d = s_axi_rdata_out;
            rsp = s_axi_rresp_out;
            s_axi_rready_in <= 1'b0;
         end
      end
   endtask

   task automatic stp(input [31:0] r1, input [31:0] r2, input bit lvm, input bit off, input integer cnt);
      wr(4'h0, r1);
      wr(4'h4, r2);
      @(posedge clk_in);
      stop_cmd <= 1'b1;
      @(posedge clk_in);
      stop_cmd <= 1'b0;
      repeat (8) @(posedge clk_in);
      cmp(in_stop_out, 1);
      cmp(osc_off_in_stop_out, off);
      if (lvm) lvm_reset_req_in <= 1'b1;
      else wr(4'hc, 32'h0000_0002);
      n = 0;
      while (cpu_run_out !== 1'b1 && n < 20000) begin
         @(posedge clk_in);
         n = n + 1;
         if (n == 6) cmp(lvm_reset_out, lvm);
         if (n == 12) lvm_reset_req_in <= 1'b0;
      end
      cmp(n > cnt * 4 - 30 && n < cnt * 4 + 30, 1);
      rd(4'h8);
      cmp(rd_d, {27'h000_0000, lvm, 4'b0001});
      $display("stop test done after %0d cycles", n);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Ceiling covers three long recoveries plus register traffic
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         err_total = err_total + 1;
         end_of_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      por_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      cmp(cfg, ex());
      $display("reset test done");
      for (i = 0; i < 8; i = i + 1) begin
         wr(4'h0, $random(seed));
         wr(4'h4, $random(seed));
         repeat (3) @(posedge clk_in);
         cmp(cfg, ex());
         rd(4'h0);
         cmp(rd_d, {24'h00_0000, m1});
         rd(4'h4);
         cmp(rd_d, {24'h00_0000, m2});
      end
      rd(4'h2);
      cmp(rsp, 2'b10);
      $display("register test done");
      wr(4'h4, 32'h0000_0004);
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      m1 = 0;
      m2 = 0;
      repeat (4) @(posedge clk_in);
      cmp(cfg, ex());
      rst_in <= 1'b1;
      por_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      por_in <= 1'b0;
      trip = 0;
      n = 0;
      while (cpu_run_out !== 1'b1 && n < 20000) begin
         @(posedge clk_in);
         n = n + 1;
      end
      cmp(cfg, ex());
      cmp(n > 16354 && n < 16424, 1);
      $display("power on test done");
      wr(4'h4, 32'h0000_0000);
      stop_cmd <= 1'b1;
      @(posedge clk_in);
      stop_cmd <= 1'b0;
      k = 0;
      repeat (5) begin
         @(posedge clk_in);
         k = k | stop_illegal_out;
      end
      cmp(k, 1);
      cmp(in_stop_out, 0);
      $display("illegal stop test done");
      stp(32'h0000_0004, 32'h0000_0018, 0, 0, 32);
      stp(32'h0000_0004, 32'h0000_0018, 1, 0, 4096);
      stp(32'h0000_0006, 32'h0000_0010, 0, 1, 4096);
      end_of_test();
   end
endmodule // tb
